/* File: src/timer_pkg.sv */
// constants shared by the reloading down-counter timer
// assumes a single 25 MHz core clock; no other package is needed
package timer_pkg;

  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned COUNT_W    = 16;
  localparam int unsigned SYNC_W     = 15;

  // select codes, high bit first
  localparam logic [1:0] SEL_CNT_LO  = 2'h0;
  localparam logic [1:0] SEL_CNT_HI  = 2'h1;
  localparam logic [1:0] SEL_LAT_LO  = 2'h2;
  localparam logic [1:0] SEL_LAT_HI  = 2'h3;

  // write_not_read levels
  localparam logic       WNR_READ    = 1'b1;
  localparam logic       WNR_WRITE   = 1'b0;

  // mode input levels
  localparam logic       MODE_ONESHOT = 1'b0;
  localparam logic       MODE_CONT    = 1'b1;

  // values after reset, plus counter zero and one
  localparam logic [7:0]  LATCH_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam logic [7:0]  BUS_RST    = 8'h00;
  localparam logic        TOGGLE_RST = 1'b0;

  // clock and pulse timing
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned SET_PULSE_CYC  = 1;
  localparam int unsigned CLR_PULSE_CYC  = 1;

  typedef enum logic [1:0] {
    ST_BLOCKED,
    ST_ARMED,
    ST_SPENT
  } irq_state_t;

endpackage

/* File: src/sync2.sv */
// two-flop synchroniser for a bundle of pin levels
// assumes the bundle bits are independent levels; clocked on the falling edge
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  always_ff @(negedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* File: src/reloading_down_counter_timer.sv */
// 16-bit reloading down-counter timer with byte-wide processor port
// assumes pins arrive asynchronously and are synchronised here; all state moves
// on the falling edge of core_clk_i
`timescale 1ns/1ns
`default_nettype none

// Operation
// R1: two byte reload latches feed 16-bit counter
// R2: loaded counter decrements once per clock
// R3: zero with interrupts unblocked pulses set low
// R4: zero reloads counter from latches, keeps counting
// R5: one-shot: only first zero interrupts until reload
// R6: continuous: every zero reloads and interrupts
// R7: continuous: toggle starts low, inverts each zero
// R8: one-shot toggles once; high-count write forces low
// R9: mode low one-shot, high continuous
// R10: write_not_read high reads, low writes
// R11: select 00/01/10/11 reads counter lo/hi, latch lo/hi
// R12: select bit0 low writes low latch only
// R13: 01 writes high latch and loads; 11 latch only
// R14: high-count load starts new countdown
// R15: clear pulse on low-count read, high writes
// R16: deselected: bus released, latch writes ignored
// R17: timer reset clears flags, keeps counter, blocks
// R18: after reset counter write re-enables interrupts
// R19: timer reset drives toggle low
// R20: state updates on clock falling edge
// R21: drive data bus only during reads
// R22: count only while count enable low
// R23: set pulse lasts exactly one clock
// R24: timer reset acts while held
// R25: other reads have no side effect
module reloading_down_counter_timer #(
  parameter int unsigned COUNT_W = timer_pkg::COUNT_W,
  parameter int unsigned BYTE_W  = timer_pkg::BYTE_W
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  // processor port
  input  wire logic [1:0]        reg_select_i,
  input  wire logic              write_not_read_i,
  input  wire logic              cell_select_i,
  input  wire logic [BYTE_W-1:0] data_bus_i,
  output logic      [BYTE_W-1:0] data_bus_o,
  output logic                   data_bus_oe_o,
  // timer control
  input  wire logic              timer_reset_n_i,
  input  wire logic              mode_i,
  input  wire logic              count_enable_n_i,
  // timer outputs
  output logic                   irq_set_pulse_n_o,
  output logic                   irq_clear_pulse_n_o,
  output logic                   toggle_out_o
);

  // synchronised pins
  logic [timer_pkg::SYNC_W-1:0] pins_s;
  logic [1:0]                   sel_s;
  logic                         wnr_s;
  logic                         cs_s;
  logic [BYTE_W-1:0]            data_s;
  logic                         trst_n_s;
  logic                         mode_s;
  logic                         cen_n_s;

  // state
  logic                         cs_d1_q;
  logic [BYTE_W-1:0]            lat_lo_q;
  logic [BYTE_W-1:0]            lat_hi_q;
  logic [COUNT_W-1:0]           cnt_q;
  logic [COUNT_W-1:0]           cnt_d;
  timer_pkg::irq_state_t        state_q;
  timer_pkg::irq_state_t        state_d;

  // decode
  wire                          access_w;
  wire                          rd_w;
  wire                          wr_w;
  wire                          wr_lat_lo_w;
  wire                          wr_lat_hi_w;
  wire                          load_w;
  wire                          clr_pulse_w;
  wire                          tick_w;
  wire                          zero_w;
  wire                          irq_fire_w;
  wire                          rd_drive_w;
  wire [BYTE_W-1:0]             rd_data_w;
  wire [COUNT_W-1:0]            reload_w;

  sync2 #(
    .W (timer_pkg::SYNC_W)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    ({reg_select_i, write_not_read_i, cell_select_i, data_bus_i,
                  timer_reset_n_i, mode_i, count_enable_n_i}),
    .sync_o     (pins_s)
  );

  assign {sel_s, wnr_s, cs_s, data_s, trst_n_s, mode_s, cen_n_s} = pins_s;

  // read source selection
  function automatic logic [BYTE_W-1:0] read_mux(
    input logic [1:0]         sel,
    input logic [COUNT_W-1:0] cnt,
    input logic [BYTE_W-1:0]  lo,
    input logic [BYTE_W-1:0]  hi
  );
    logic [BYTE_W-1:0] r;
    r = lo;
    unique case (sel)
      timer_pkg::SEL_CNT_LO: r = cnt[BYTE_W-1:0];
      timer_pkg::SEL_CNT_HI: r = cnt[COUNT_W-1:BYTE_W];
      timer_pkg::SEL_LAT_LO: r = lo;
      timer_pkg::SEL_LAT_HI: r = hi;
    endcase
    return r;
  endfunction

  // one access per rising cell select; nothing happens while deselected
  assign access_w    = cs_s & ~cs_d1_q;                                  // [R16]
  assign rd_w        = access_w & (wnr_s == timer_pkg::WNR_READ);        // [R10]
  assign wr_w        = access_w & (wnr_s == timer_pkg::WNR_WRITE);       // [R10]
  assign wr_lat_lo_w = wr_w & ~sel_s[0];                                 // [R12]
  assign wr_lat_hi_w = wr_w & sel_s[0];                                  // [R13]
  assign load_w      = wr_w & (sel_s == timer_pkg::SEL_CNT_HI);          // [R13] [R14]
  assign clr_pulse_w = (rd_w & (sel_s == timer_pkg::SEL_CNT_LO)) | wr_lat_hi_w; // [R15] [R25]
  assign rd_drive_w  = cs_s & (wnr_s == timer_pkg::WNR_READ);            // [R21]
  assign rd_data_w   = read_mux(sel_s, cnt_q, lat_lo_q, lat_hi_q);       // [R11]

  // counting
  assign tick_w      = ~cen_n_s;                                         // [R22]
  assign zero_w      = tick_w & (cnt_q == timer_pkg::COUNT_ZERO) & ~load_w;
  assign reload_w    = {lat_hi_q, lat_lo_q};                             // [R1]
  assign irq_fire_w  = zero_w & (state_q == timer_pkg::ST_ARMED) & trst_n_s; // [R3]

  always_comb
  begin
    cnt_d = cnt_q;
    if (load_w)
      cnt_d = {data_s, lat_lo_q};                                        // [R14]
    else if (zero_w)
      cnt_d = reload_w;                                                  // [R4]
    else if (tick_w)
      cnt_d = cnt_q - timer_pkg::COUNT_ONE;                              // [R2]
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      timer_pkg::ST_BLOCKED: if (load_w) state_d = timer_pkg::ST_ARMED;  // [R18]
      timer_pkg::ST_ARMED:
        if (load_w)
          state_d = timer_pkg::ST_ARMED;
        else if (irq_fire_w && mode_s == timer_pkg::MODE_ONESHOT)
          state_d = timer_pkg::ST_SPENT;                                 // [R5] [R9]
      timer_pkg::ST_SPENT:   if (load_w) state_d = timer_pkg::ST_ARMED;  // [R5]
      default:               state_d = timer_pkg::ST_BLOCKED;
    endcase
    if (!trst_n_s)
      state_d = timer_pkg::ST_BLOCKED;                                   // [R17] [R24]
  end

  always_ff @(negedge core_clk_i or posedge reset_i)                     // [R20]
  begin
    if (reset_i)
    begin
      cs_d1_q  <= 1'b0;
      lat_lo_q <= timer_pkg::LATCH_RST;
      lat_hi_q <= timer_pkg::LATCH_RST;
      cnt_q    <= timer_pkg::COUNT_RST;
      state_q  <= timer_pkg::ST_BLOCKED;
    end
    else
    begin
      cs_d1_q  <= cs_s;
      if (wr_lat_lo_w)
        lat_lo_q <= data_s;                                              // [R12]
      if (wr_lat_hi_w)
        lat_hi_q <= data_s;                                              // [R13]
      cnt_q    <= cnt_d;                                                 // [R17]
      state_q  <= state_d;
    end
  end

  // outputs, all registered
  always_ff @(negedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      irq_set_pulse_n_o   <= 1'b1;
      irq_clear_pulse_n_o <= 1'b1;
      toggle_out_o        <= timer_pkg::TOGGLE_RST;
      data_bus_o          <= timer_pkg::BUS_RST;
      data_bus_oe_o       <= 1'b0;
    end
    else
    begin
      irq_set_pulse_n_o   <= ~irq_fire_w;                                // [R3] [R6] [R23]
      irq_clear_pulse_n_o <= ~clr_pulse_w;                               // [R15]
      data_bus_o          <= rd_data_w;
      data_bus_oe_o       <= rd_drive_w;                                 // [R21] [R16]
      if (!trst_n_s || load_w)
        toggle_out_o <= timer_pkg::TOGGLE_RST;                           // [R8] [R19]
      else if (irq_fire_w)
        toggle_out_o <= ~toggle_out_o;                                   // [R7] [R8]
    end
  end

  // checks
  sequence clr_low_one;
    !irq_clear_pulse_n_o ##1 irq_clear_pulse_n_o;
  endsequence

  sequence set_low_one;
    !irq_set_pulse_n_o ##1 irq_set_pulse_n_o;
  endsequence

  a_set_pulse_width: assert property ( // [R23]
    @(negedge core_clk_i) disable iff (reset_i)
    irq_fire_w |=> set_low_one)
    else $error("set pulse not exactly one clock");

  a_set_cause: assert property ( // [R3]
    @(negedge core_clk_i) disable iff (reset_i)
    $fell(irq_set_pulse_n_o) |-> $past(zero_w) && $past(state_q) == timer_pkg::ST_ARMED)
    else $error("set pulse without armed zero");

  a_blocked_quiet: assert property ( // [R18]
    @(negedge core_clk_i) disable iff (reset_i)
    state_q == timer_pkg::ST_BLOCKED |=> irq_set_pulse_n_o)
    else $error("interrupt while blocked");

  a_oneshot_once: assert property ( // [R5]
    @(negedge core_clk_i) disable iff (reset_i)
    irq_fire_w && mode_s == timer_pkg::MODE_ONESHOT |=> state_q == timer_pkg::ST_SPENT)
    else $error("one-shot did not stop after first zero");

  a_load_value: assert property ( // [R14]
    @(negedge core_clk_i) disable iff (reset_i)
    load_w |=> cnt_q == $past({data_s, lat_lo_q}) && lat_hi_q == $past(data_s))
    else $error("counter load value wrong");

  a_decrement: assert property ( // [R2]
    @(negedge core_clk_i) disable iff (reset_i)
    tick_w && !load_w && cnt_q != timer_pkg::COUNT_ZERO |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("counter did not decrement");

  a_hold_disabled: assert property ( // [R22]
    @(negedge core_clk_i) disable iff (reset_i)
    !tick_w && !load_w |=> $stable(cnt_q))
    else $error("counter moved while disabled");

  a_reload: assert property ( // [R4]
    @(negedge core_clk_i) disable iff (reset_i)
    zero_w |=> cnt_q == $past(reload_w))
    else $error("counter not reloaded at zero");

  a_toggle_load: assert property ( // [R8]
    @(negedge core_clk_i) disable iff (reset_i)
    load_w |=> !toggle_out_o)
    else $error("toggle not forced low on load");

  a_toggle_flip: assert property ( // [R7]
    @(negedge core_clk_i) disable iff (reset_i)
    irq_fire_w && trst_n_s && !load_w |=> toggle_out_o != $past(toggle_out_o))
    else $error("toggle did not invert at zero");

  a_clear_pulse: assert property ( // [R15]
    @(negedge core_clk_i) disable iff (reset_i)
    clr_pulse_w |=> clr_low_one)
    else $error("clear pulse wrong");

  a_bus_release: assert property ( // [R21]
    @(negedge core_clk_i) disable iff (reset_i)
    !cs_s || wnr_s == timer_pkg::WNR_WRITE |=> !data_bus_oe_o)
    else $error("bus driven outside a read");

  a_deselect_hold: assert property ( // [R16]
    @(negedge core_clk_i) disable iff (reset_i)
    !cs_s |=> $stable(lat_lo_q) && $stable(lat_hi_q))
    else $error("latch written while deselected");

  a_timer_reset: assert property ( // [R17]
    @(negedge core_clk_i) disable iff (reset_i)
    !trst_n_s |=> irq_set_pulse_n_o && !toggle_out_o && state_q == timer_pkg::ST_BLOCKED)
    else $error("timer reset effect missing");

  a_read_data: assert property ( // [R11]
    @(negedge core_clk_i) disable iff (reset_i)
    rd_drive_w && sel_s == timer_pkg::SEL_LAT_HI |=> data_bus_o == $past(lat_hi_q))
    else $error("read mux wrong");

  a_read_cnt_lo: assert property ( // [R11]
    @(negedge core_clk_i) disable iff (reset_i)
    rd_drive_w && sel_s == timer_pkg::SEL_CNT_LO |=> data_bus_o == $past(cnt_q[BYTE_W-1:0]))
    else $error("low counter read wrong");

  a_read_lat_lo: assert property ( // [R11]
    @(negedge core_clk_i) disable iff (reset_i)
    rd_drive_w && sel_s == timer_pkg::SEL_LAT_LO |=> data_bus_o == $past(lat_lo_q))
    else $error("low latch read wrong");

  a_bus_drive: assert property ( // [R21]
    @(negedge core_clk_i) disable iff (reset_i)
    rd_drive_w |=> data_bus_oe_o)
    else $error("bus not driven during read");

  a_cont_rearm: assert property ( // [R6]
    @(negedge core_clk_i) disable iff (reset_i)
    irq_fire_w && mode_s == timer_pkg::MODE_CONT |=> state_q == timer_pkg::ST_ARMED)
    else $error("continuous mode stopped interrupting");

  a_spent_quiet: assert property ( // [R5]
    @(negedge core_clk_i) disable iff (reset_i)
    state_q == timer_pkg::ST_SPENT |=> irq_set_pulse_n_o)
    else $error("one-shot pulsed again");

  a_rearm_load: assert property ( // [R18]
    @(negedge core_clk_i) disable iff (reset_i)
    load_w && trst_n_s |=> state_q == timer_pkg::ST_ARMED)
    else $error("load did not re-enable interrupts");

  a_toggle_hold: assert property ( // [R8]
    @(negedge core_clk_i) disable iff (reset_i)
    trst_n_s && !load_w && !irq_fire_w |=> $stable(toggle_out_o))
    else $error("toggle moved without a zero");

  a_lat_lo_write: assert property ( // [R12]
    @(negedge core_clk_i) disable iff (reset_i)
    wr_lat_lo_w |=> lat_lo_q == $past(data_s) && $stable(lat_hi_q))
    else $error("low latch write wrong");

  a_lat_hi_only: assert property ( // [R13]
    @(negedge core_clk_i) disable iff (reset_i)
    wr_w && sel_s == timer_pkg::SEL_LAT_HI |=> lat_hi_q == $past(data_s) && $stable(lat_lo_q))
    else $error("high latch write wrong");

  a_clear_quiet: assert property ( // [R25]
    @(negedge core_clk_i) disable iff (reset_i)
    !clr_pulse_w |=> irq_clear_pulse_n_o)
    else $error("clear pulse without cause");

endmodule
`default_nettype wire

/* File: verif/cpu_bus_model.sv */
// processor-side bus model: byte accesses with setup, hold and release
// assumes the cell synchronises its pins on falling edges, 2 flops deep
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model (
  // clock
  input  wire logic       clk_i,
  // pins to the cell
  output logic      [1:0] sel_o,
  output logic            wnr_o,
  output logic            cs_o,
  output logic      [7:0] data_o,
  // cell drive
  input  wire logic [7:0] dev_d_i,
  input  wire logic       dev_oe_i
);
  logic       drv_q  = 1'b0;
  logic [7:0] wd_q   = 8'h00;
  logic [7:0] last_q = 8'h00;

  // a released bus shows the inverse of its last level
  assign data_o = dev_oe_i ? dev_d_i : (drv_q ? wd_q : ~last_q);
  always @(posedge clk_i) last_q <= data_o;
  initial
  begin
    sel_o = 2'h0;
    wnr_o = 1'b1;
    cs_o  = 1'b0;
  end

  // pins settle 3 cycles, select held 4, then dropped for 3
  task automatic access(input logic [1:0] s, input logic w, input logic c,
                        input logic [7:0] d, output logic [7:0] q, output logic oe);
    sel_o <= s;
    wnr_o <= w;
    drv_q <= ~w;
    wd_q  <= d;
    repeat (3) @(posedge clk_i);
    cs_o <= c;
    repeat (4) @(posedge clk_i);
    q  = data_o;
    oe = dev_oe_i;
    cs_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    drv_q <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/reloading_down_counter_timer_tb_top.sv */
// self-checking bench for the reloading down-counter timer
// assumes cpu_bus_model drives the processor pins; timer pins are driven here
`timescale 1ns/1ns
`default_nettype none
module reloading_down_counter_timer_tb_top;
  logic       core_clk  = 1'b0;
  logic       reset     = 1'b1;
  logic       tmr_rst_n = 1'b1;
  logic       mode      = 1'b0;
  logic       cen_n     = 1'b1;
  logic [1:0] sel;
  logic       wnr;
  logic       cs;
  logic [7:0] bus;
  logic [7:0] dout;
  logic       oe;
  logic       set_n;
  logic       clr_n;
  logic       tog;
  logic       tog_q     = 1'b0;
  int         set_cnt   = 0;
  int         clr_cnt   = 0;
  int         tog_cnt   = 0;
  int         bad_count = 0;
  int         compares  = 0;

  always #(timer_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  cpu_bus_model cpu (.clk_i(core_clk), .sel_o(sel), .wnr_o(wnr), .cs_o(cs), .data_o(bus),
                     .dev_d_i(dout), .dev_oe_i(oe));
  reloading_down_counter_timer DUT (
    .core_clk_i(core_clk), .reset_i(reset), .reg_select_i(sel), .write_not_read_i(wnr),
    .cell_select_i(cs), .data_bus_i(bus), .data_bus_o(dout), .data_bus_oe_o(oe),
    .timer_reset_n_i(tmr_rst_n), .mode_i(mode), .count_enable_n_i(cen_n),
    .irq_set_pulse_n_o(set_n), .irq_clear_pulse_n_o(clr_n), .toggle_out_o(tog));

  // outputs move on falling edges, so rising edges see them settled
  always @(posedge core_clk)
  begin
    set_cnt += int'(set_n === 1'b0);
    clr_cnt += int'(clr_n === 1'b0);
    tog_cnt += int'(tog !== tog_q);
    tog_q = tog;
  end

  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    logic [7:0] q;
    logic       o;
    cpu.access(s, 1'b0, 1'b1, d, q, o);
  endtask

  task automatic rd(input logic [1:0] s, output logic [7:0] q);
    logic o;
    cpu.access(s, 1'b1, 1'b1, 8'h00, q, o);
    check("read drive", 16'(o), 16'h0001);
  endtask

  task automatic wait_set;
    int i;
    i = 0;
    while (set_n !== 1'b0 && i < 50)
    begin
      @(posedge core_clk);
      i++;
    end
    if (set_n !== 1'b0)
    begin
      bad_count++;
      $display("[FAIL] set pulse expected 0 seen 1");
      stop_test();
    end
  endtask

  // counts pulses and toggles over 32 cycles after the current edge
  task automatic win(input int es, input int et);
    int s0;
    int t0;
    #1;
    s0 = set_cnt;
    t0 = tog_cnt;
    repeat (32) @(posedge core_clk);
    #1;
    check("set pulses", 16'(set_cnt - s0), 16'(es));
    check("toggles", 16'(tog_cnt - t0), 16'(et));
    // realign to a rising edge so the next stimulus lands on it
    @(posedge core_clk);
  endtask

  // load 0x0003 with counting held, then count down to the first zero
  task automatic load_run(input logic m);
    cen_n <= 1'b1;
    mode  <= m;
    wr(2'h1, 8'h00);
    check("toggle at load", 16'(tog), 16'h0000);
    cen_n <= 1'b0;
    wait_set();
  endtask

  task automatic t_reset;
    check("set idle", 16'(set_n), 16'h0001);
    check("clear idle", 16'(clr_n), 16'h0001);
    check("toggle idle", 16'(tog), 16'h0000);
    check("bus idle", 16'(oe), 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_regs;
    logic [7:0] q;
    logic       o;
    int         c0;
    c0 = clr_cnt;
    wr(2'h0, 8'ha5);
    rd(2'h2, q);
    check("low latch", 16'(q), 16'h00a5);
    wr(2'h2, 8'h3c);
    rd(2'h2, q);
    check("low latch 10", 16'(q), 16'h003c);
    wr(2'h3, 8'hc3);
    rd(2'h3, q);
    check("high latch", 16'(q), 16'h00c3);
    rd(2'h1, q);
    check("count kept", 16'(q), 16'h0000);
    cpu.access(2'h0, 1'b0, 1'b0, 8'hff, q, o);
    cpu.access(2'h2, 1'b1, 1'b0, 8'h00, q, o);
    check("deselected drive", 16'(o), 16'h0000);
    rd(2'h2, q);
    check("deselected write", 16'(q), 16'h003c);
    check("clear pulses a", 16'(clr_cnt - c0), 16'h0001);
    c0 = clr_cnt;
    wr(2'h1, 8'h12);
    rd(2'h0, q);
    check("count low", 16'(q), 16'h003c);
    rd(2'h1, q);
    check("count high", 16'(q), 16'h0012);
    check("clear pulses b", 16'(clr_cnt - c0), 16'h0002);
    $display("register test done");
  endtask

  task automatic t_cont;
    wr(2'h0, 8'h03);
    load_run(1'b1);
    win(8, 8);
    $display("continuous test done");
  endtask

  task automatic t_treset;
    tmr_rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    win(0, 0);
    check("toggle held low", 16'(tog), 16'h0000);
    tmr_rst_n <= 1'b1;
    win(0, 0);
    load_run(1'b1);
    $display("timer reset test done");
  endtask

  task automatic t_oneshot;
    load_run(1'b0);
    win(0, 0);
    check("toggle once", 16'(tog), 16'h0001);
    load_run(1'b0);
    $display("one-shot test done");
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_regs();
    t_cont();
    t_treset();
    t_oneshot();
    stop_test();
  end
endmodule
`default_nettype wire
